// File: design/sspr_pkg.sv
// constants, register map and state codes of the pairing/status controller
package sspr_pkg;
	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned MS_HZ           = 1_000;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_HZ;
	localparam int unsigned MS_PER_S        = 1_000;
	localparam int unsigned MS_PER_QSEC     = 250;
	localparam int unsigned FL3_PERIOD_MS   = 333;  // 3 Hz
	localparam int unsigned FL3_ON_MS       = 50;   // brief flash
	localparam int unsigned TEACH_S         = 10;
	localparam int unsigned OFFREQ_MIN      = 5;
	localparam int unsigned OFFREQ_S        = OFFREQ_MIN * 60;
	localparam int unsigned INHIB_MIN       = 10;
	localparam int unsigned INHIB_S         = INHIB_MIN * 60;
	localparam logic [3:0]  FLASH_OVERTEMP  = 4'h4;
	localparam logic [3:0]  FLASH_WRONG_ACT = 4'h5;
	// ----------------------------------------------------------------
	// parameter port
	// ----------------------------------------------------------------
	localparam logic [3:0]  PARAM_DIAG_REQ  = 4'hf;
	localparam logic [3:0]  PARAM_DEFAULT   = 4'hf;
	localparam int unsigned P_PRESENT       = 0;
	localparam int unsigned P_HYST          = 1;
	localparam int unsigned P_INHIB         = 2;
	localparam int unsigned P_DEV_ERR       = 3;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam logic [7:0]  REG_CODE        = 8'h08;
	localparam logic [7:0]  REG_PARAM       = 8'h0c;
	localparam int unsigned CTRL_REPEAT     = 0;
	localparam int unsigned CTRL_ACT_NUM    = 1;
	localparam logic [1:0]  CTRL_RESET      = 2'h0;
	// ----------------------------------------------------------------
	// pairing states, gray along the teach path
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_UNPAIRED = 3'h0,
		S_TEACH    = 3'h1,
		S_OFFREQ   = 3'h3,
		S_CONFIRM  = 3'h2,
		S_RUN      = 3'h6,
		S_ABORT    = 3'h7
	} sspr_state_t;
endpackage

// File: design/sspr_tick_if.sv
// ticks and flash phases from the time base to the controller
`timescale 1ns/100ps
interface sspr_tick_if;
	logic       ms_tick;    // one cycle per millisecond
	logic       sec_tick;   // one cycle per second
	logic [3:0] qsec_phase; // quarter seconds, wraps at 4 s
	logic       brief3;     // brief 3 Hz flash
	modport src (output ms_tick, sec_tick, qsec_phase, brief3);
	modport snk (input ms_tick, sec_tick, qsec_phase, brief3);
endinterface // sspr_tick_if

// File: design/sspr_timebase.sv
// single time base: millisecond, second and flash phase ticks
`timescale 1ns/100ps
module sspr_timebase #(
	parameter int unsigned CYC_PER_MS = sspr_pkg::CYC_PER_MS
) (
	input  wire logic clk_i,   // 40 MHz clock
	input  wire logic rst_i,   // sync reset, high
	sspr_tick_if.src  tk       // tick outputs
);
	logic [15:0] cyc_q;
	logic [9:0]  ms_q;
	logic [7:0]  qms_q;
	logic [8:0]  f3_q;
	logic        ms_end;

	assign ms_end = (cyc_q == 16'(CYC_PER_MS - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc_q      <= '0;
			tk.ms_tick <= 1'b0;
		end else begin
			cyc_q      <= ms_end ? '0 : cyc_q + 16'h1;
			tk.ms_tick <= ms_end;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_q        <= '0;
			tk.sec_tick <= 1'b0;
		end else begin
			tk.sec_tick <= 1'b0;
			if (tk.ms_tick) begin
				if (ms_q == 10'(sspr_pkg::MS_PER_S - 1)) begin
					ms_q        <= '0;
					tk.sec_tick <= 1'b1;
				end else begin
					ms_q <= ms_q + 10'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			qms_q         <= '0;
			tk.qsec_phase <= '0;
		end else if (tk.ms_tick) begin
			if (qms_q == 8'(sspr_pkg::MS_PER_QSEC - 1)) begin
				qms_q         <= '0;
				tk.qsec_phase <= tk.qsec_phase + 4'h1;
			end else begin
				qms_q <= qms_q + 8'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f3_q      <= '0;
			tk.brief3 <= 1'b0;
		end else if (tk.ms_tick) begin
			f3_q <= (f3_q == 9'(sspr_pkg::FL3_PERIOD_MS - 1)) ?
				'0 : f3_q + 9'h1;
			tk.brief3 <= (f3_q < 9'(sspr_pkg::FL3_ON_MS));
		end
	end

	a_ms_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i)
		tk.ms_tick |=> !tk.ms_tick)
		else $error("ms tick longer than one cycle");
endmodule // sspr_timebase

// File: design/sspr_top.sv
// pairing, tamper inhibit, diagnostics and indicator control
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module sspr_top #(
	parameter int unsigned CODE_W     = 8,
	parameter int unsigned CYC_PER_MS = sspr_pkg::CYC_PER_MS,
	parameter int unsigned TEACH_S    = sspr_pkg::TEACH_S,
	parameter int unsigned OFFREQ_S   = sspr_pkg::OFFREQ_S,
	parameter int unsigned INHIB_S    = sspr_pkg::INHIB_S
) (
	input  wire logic              clk_i,        // 40 MHz clock
	input  wire logic              rst_i,        // sync reset, high
	input  wire logic [7:0]        wb_adr_i,     // byte address
	input  wire logic [31:0]       wb_dat_i,     // write data
	output logic      [31:0]       wb_dat_o,     // read data
	input  wire logic              wb_we_i,      // write
	input  wire logic [3:0]        wb_sel_i,     // byte enables
	input  wire logic              wb_cyc_i,     // cycle
	input  wire logic              wb_stb_i,     // strobe
	output logic                   wb_ack_o,     // acknowledge
	input  wire logic              power_on_i,   // operating supply up
	input  wire logic              act_present_i,// actuator in range
	input  wire logic [CODE_W-1:0] act_code_i,   // actuator code
	input  wire logic [3:0]        act_num_i,    // actuator number
	input  wire logic              hyst_i,       // in hysteresis area
	input  wire logic              overtemp_i,   // over-temperature
	input  wire logic              defect_i,     // internal defect
	input  wire logic              addr_zero_i,  // slave address 0
	input  wire logic              comm_err_i,   // bus comm error
	input  wire logic [3:0]        dyn_code_i,   // dynamic code word
	input  wire logic              param_wr_i,   // parameter write
	input  wire logic [3:0]        param_val_i,  // parameter value
	output logic      [3:0]        param_ans_o,  // parameter answer
	output logic      [3:0]        code_o,       // safe input code
	output logic                   periph_err_o, // periphery error
	output logic                   led_red_o,    // duo led red
	output logic                   led_green_o,  // duo led green
	output logic                   led_yellow_o  // yellow led
);
	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	sspr_tick_if tk ();
	sspr_timebase #(.CYC_PER_MS(CYC_PER_MS)) u_tb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tk    (tk)
	);

	function automatic logic burst(input logic [3:0] n,
		input logic [3:0] ph);
		burst = (ph < {n[2:0], 1'b0}) && !ph[0];
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	sspr_pkg::sspr_state_t st_q;
	logic [1:0]        ctrl_q;
	logic              pwr_q;
	logic              armed_q;
	logic [CODE_W-1:0] stored_q;
	logic              stored_v_q;
	logic [CODE_W-1:0] pend_q;
	logic              pend_v_q;
	logic [8:0]        sec_q;
	logic [9:0]        inh_cnt_q;
	logic              inhib_q;
	logic              inh_wait_q;
	logic              ot_q;
	logic              wrong_q;
	logic              def_q;
	logic              opened_q;
	logic              repeat_v;
	logic              actnum_v;
	logic              pwr_up;
	logic              pwr_dn;
	logic              teach_go;
	logic              err_any;
	logic              bus_err;
	logic              rg_flash;
	logic              wrong_now;
	logic              release_ok;
	logic [3:0]        diag;

	assign repeat_v  = ctrl_q[sspr_pkg::CTRL_REPEAT];
	assign actnum_v  = ctrl_q[sspr_pkg::CTRL_ACT_NUM];
	assign pwr_up    = power_on_i && !pwr_q;
	assign pwr_dn    = !power_on_i && pwr_q;
	assign bus_err   = addr_zero_i || comm_err_i;
	assign err_any   = ot_q || wrong_q || def_q;
	// one_time_pairing_variant when repeat_v is low
	assign teach_go  = armed_q && act_present_i && power_on_i
		&& (!stored_v_q || act_code_i != stored_q)
		&& (repeat_v || !stored_v_q);
	assign wrong_now = st_q == sspr_pkg::S_RUN && act_present_i
		&& !armed_q && act_code_i != stored_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_q <= 1'b0;
		end else begin
			pwr_q <= power_on_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_q <= 1'b0;
		end else if (pwr_up) begin
			armed_q <= 1'b1;
		end else if (act_present_i) begin
			armed_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// teach sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= sspr_pkg::S_UNPAIRED;
			sec_q <= '0;
		end else if (pwr_dn) begin
			st_q  <= stored_v_q ? sspr_pkg::S_RUN : sspr_pkg::S_UNPAIRED;
			sec_q <= '0;
		end else if (pwr_up) begin
			st_q <= pend_v_q ? sspr_pkg::S_CONFIRM : st_q;
		end else begin
			if (tk.sec_tick) begin
				sec_q <= sec_q + 9'h1;
			end
			unique case (st_q)
				sspr_pkg::S_UNPAIRED, sspr_pkg::S_RUN: begin
					if (teach_go) begin
						st_q  <= sspr_pkg::S_TEACH;
						sec_q <= '0;
					end
				end
				sspr_pkg::S_TEACH: begin
					if (!act_present_i) begin
						st_q <= stored_v_q ? sspr_pkg::S_RUN
							: sspr_pkg::S_UNPAIRED;
					end else if (tk.sec_tick
						&& sec_q == 9'(TEACH_S - 1)) begin
						st_q  <= sspr_pkg::S_OFFREQ;
						sec_q <= '0;
					end
				end
				sspr_pkg::S_OFFREQ: begin
					if (tk.sec_tick && sec_q == 9'(OFFREQ_S - 1)) begin
						st_q <= sspr_pkg::S_ABORT;
					end
				end
				sspr_pkg::S_CONFIRM: begin
					if (act_present_i && act_code_i == pend_q) begin
						st_q <= sspr_pkg::S_RUN;
					end
				end
				sspr_pkg::S_ABORT: begin
					if (!act_present_i) begin
						st_q <= stored_v_q ? sspr_pkg::S_RUN
							: sspr_pkg::S_UNPAIRED;
					end
				end
				default: st_q <= sspr_pkg::S_UNPAIRED;
			endcase
		end
	end

	// learned code held pending until confirmed after power-up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q   <= '0;
			pend_v_q <= 1'b0;
		end else if (st_q == sspr_pkg::S_TEACH) begin
			pend_q   <= act_code_i;
			pend_v_q <= 1'b0;
		end else if (pwr_dn && st_q == sspr_pkg::S_OFFREQ) begin
			pend_v_q <= 1'b1;
		end else if (st_q == sspr_pkg::S_CONFIRM && act_present_i
			&& act_code_i == pend_q) begin
			pend_v_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stored_q   <= '0;
			stored_v_q <= 1'b0;
		end else if (st_q == sspr_pkg::S_CONFIRM && act_present_i
			&& act_code_i == pend_q && !pwr_dn) begin
			stored_q   <= pend_q;
			stored_v_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// tamper inhibit
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inhib_q   <= 1'b0;
			inh_cnt_q <= '0;
		end else if (st_q == sspr_pkg::S_CONFIRM && act_present_i
			&& act_code_i == pend_q && repeat_v && !pwr_dn) begin
			inhib_q   <= 1'b1;
			inh_cnt_q <= 10'(INHIB_S);
		end else if (pwr_up && inhib_q) begin
			inh_cnt_q <= 10'(INHIB_S);
		end else if (inhib_q && power_on_i && tk.sec_tick) begin
			inh_cnt_q <= inh_cnt_q - 10'h1;
			if (inh_cnt_q == 10'h1) begin
				inhib_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inh_wait_q <= 1'b0;
		end else if (inhib_q) begin
			inh_wait_q <= 1'b1;
		end else if (act_present_i && power_on_i) begin
			inh_wait_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// latched faults, cleared by opening and closing the guard
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opened_q <= 1'b0;
		end else if (!err_any) begin
			opened_q <= 1'b0;
		end else if (!act_present_i) begin
			opened_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ot_q    <= 1'b0;
			wrong_q <= 1'b0;
			def_q   <= 1'b0;
		end else begin
			// a new fault wins over the clearing guard cycle
			if (overtemp_i) begin
				ot_q <= 1'b1;
			end else if (opened_q && act_present_i) begin
				ot_q <= 1'b0;
			end
			if (wrong_now || st_q == sspr_pkg::S_ABORT) begin
				wrong_q <= 1'b1;
			end else if (opened_q && act_present_i) begin
				wrong_q <= 1'b0;
			end
			if (defect_i) begin
				def_q <= 1'b1;
			end else if (opened_q && act_present_i) begin
				def_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs to the bus and indicators
	// ----------------------------------------------------------------
	always_comb begin
		diag = '0;
		if (actnum_v) begin
			diag = act_present_i ? act_num_i : 4'h0;
		end else begin
			diag[sspr_pkg::P_PRESENT] = act_present_i;
			diag[sspr_pkg::P_HYST]    = hyst_i;
			diag[sspr_pkg::P_INHIB]   = inhib_q;
			diag[sspr_pkg::P_DEV_ERR] = err_any;
		end
	end

	assign release_ok = power_on_i && st_q == sspr_pkg::S_RUN
		&& stored_v_q && act_present_i && !inhib_q && !err_any
		&& !wrong_now && !bus_err;
	assign rg_flash = hyst_i || inhib_q || inh_wait_q || err_any;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_o       <= '0;
			periph_err_o <= 1'b0;
		end else begin
			code_o       <= release_ok ? dyn_code_i : 4'h0;
			periph_err_o <= hyst_i || inhib_q || err_any;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			param_ans_o <= sspr_pkg::PARAM_DEFAULT;
		end else if (param_wr_i) begin
			param_ans_o <= (param_val_i == sspr_pkg::PARAM_DIAG_REQ)
				? diag : param_val_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_red_o   <= 1'b0;
			led_green_o <= 1'b0;
		end else if (!power_on_i) begin
			led_red_o   <= 1'b0;
			led_green_o <= 1'b0;
		end else if (bus_err) begin
			led_red_o   <= 1'b1;
			led_green_o <= 1'b0;
		end else if (rg_flash) begin
			led_red_o   <= tk.qsec_phase[1];
			led_green_o <= !tk.qsec_phase[1];
		end else begin
			led_red_o   <= 1'b0;
			led_green_o <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_yellow_o <= 1'b0;
		end else if (!power_on_i || inhib_q) begin
			led_yellow_o <= 1'b0;
		end else if (def_q) begin
			led_yellow_o <= 1'b1;
		end else if (ot_q) begin
			led_yellow_o <= burst(sspr_pkg::FLASH_OVERTEMP, tk.qsec_phase);
		end else if (wrong_q) begin
			led_yellow_o <= burst(sspr_pkg::FLASH_WRONG_ACT,
				tk.qsec_phase);
		end else if (st_q == sspr_pkg::S_TEACH) begin
			led_yellow_o <= tk.qsec_phase[1];
		end else if (st_q == sspr_pkg::S_OFFREQ) begin
			led_yellow_o <= tk.brief3;
		end else if (hyst_i) begin
			led_yellow_o <= tk.qsec_phase[1];
		end else begin
			led_yellow_o <= release_ok;
		end
	end

	// ----------------------------------------------------------------
	// wishbone slave, one wait state
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			unique case (wb_adr_i)
				sspr_pkg::REG_CTRL:   wb_dat_o <= {30'h0, ctrl_q};
				sspr_pkg::REG_STATUS: wb_dat_o <= {14'h0, inh_cnt_q,
					inh_wait_q, inhib_q, def_q, wrong_q, ot_q, st_q};
				sspr_pkg::REG_CODE:   wb_dat_o <= {stored_v_q,
					31'(stored_q)};
				sspr_pkg::REG_PARAM:  wb_dat_o <= {24'h0, diag,
					param_ans_o};
				default:              wb_dat_o <= '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= sspr_pkg::CTRL_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
			&& wb_sel_i[0] && wb_adr_i == sspr_pkg::REG_CTRL) begin
			ctrl_q <= wb_dat_i[1:0];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_inhib_code_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		inhib_q |=> code_o == 4'h0 && !led_yellow_o)
		else $error("code released during inhibit");
	a_bus_err_red: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_err && power_on_i |=> led_red_o && !led_green_o
		&& code_o == 4'h0)
		else $error("bus error not shown steady red");
	a_periph_flag_or: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 periph_err_o == $past(hyst_i || inhib_q || err_any))
		else $error("periphery flag not the OR of causes");
	a_param_diag_ans: assert property (@(posedge clk_i) disable iff (rst_i)
		param_wr_i && param_val_i == 4'hf |=> param_ans_o == $past(diag))
		else $error("diagnostic answer wrong");
	a_onetime_no_teach: assert property (@(posedge clk_i)
		disable iff (rst_i)
		$rose(st_q == sspr_pkg::S_TEACH)
		|-> $past(repeat_v) || !$past(stored_v_q))
		else $error("teach accepted in one-time variant");
	a_offreq_abort: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == sspr_pkg::S_OFFREQ && tk.sec_tick && power_on_i && pwr_q
		&& sec_q == 9'(OFFREQ_S - 1) |=> st_q == sspr_pkg::S_ABORT)
		else $error("teach not aborted after timeout");
	a_inhib_restart: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_up && inhib_q |=> inh_cnt_q == 10'(INHIB_S))
		else $error("inhibit not restarted at power-up");
	a_actnum_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		actnum_v && !act_present_i |-> diag == 4'h0)
		else $error("number reported without actuator");
	a_err_clear_guard: assert property (@(posedge clk_i)
		disable iff (rst_i)
		$fell(def_q) |-> $past(opened_q) && $past(act_present_i))
		else $error("error cleared without guard cycle");
endmodule // sspr_top

// File: testbench/sspr_master_model.sv
// bus master model: diagnostic parameter polling and release evaluation
`timescale 1ns/100ps
module sspr_master_model (
	input  wire logic       clk_i,       // 40 MHz clock
	input  wire logic       poll_i,      // request one diagnostic poll
	input  wire logic [3:0] code_i,      // safe code from slave
	output logic            param_wr_o,  // parameter write strobe
	output logic      [3:0] param_val_o, // parameter value
	output logic            release_o    // derived safety release
);
	initial begin
		param_wr_o  = 1'b0;
		param_val_o = 4'h0;
		release_o   = 1'b0;
	end
	// value F asks for the diagnostic bits
	always @(posedge clk_i) begin
		param_wr_o  <= poll_i;
		param_val_o <= poll_i ? sspr_pkg::PARAM_DIAG_REQ : ~param_val_o;
	end
	// four-input or over the code bits
	always @(posedge clk_i) begin
		release_o <= |code_i;
	end
endmodule // sspr_master_model

// File: testbench/tb_top.sv
// self-checking bench of the pairing and status controller
`timescale 1ns/100ps
module tb_top;
	localparam int SEC = 4 * 1000;
	logic clk_i = 1'b0, rst_i = 1'b1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
	logic [3:0] wb_sel_i = 4'h0;
	logic power_on_i = 1'b0, act_present_i = 1'b0, hyst_i = 1'b0;
	logic overtemp_i = 1'b0, defect_i = 1'b0, addr_zero_i = 1'b0;
	logic comm_err_i = 1'b0, poll = 1'b0, param_wr, rel;
	logic [7:0] act_code_i = 8'h5a;
	logic [3:0] act_num_i = 4'h9, dyn_code_i = 4'ha, param_val;
	logic [3:0] param_ans_o, code_o;
	logic periph_err_o, led_red_o, led_green_o, led_yellow_o;
	int bad_count = 0, n_checks = 0, ones;
	always #12.5 clk_i = ~clk_i;
	sspr_top #(.CYC_PER_MS(4), .TEACH_S(2), .OFFREQ_S(3), .INHIB_S(3)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_ack_o(wb_ack_o), .power_on_i(power_on_i),
		.act_present_i(act_present_i), .act_code_i(act_code_i),
		.act_num_i(act_num_i), .hyst_i(hyst_i), .overtemp_i(overtemp_i),
		.defect_i(defect_i), .addr_zero_i(addr_zero_i),
		.comm_err_i(comm_err_i), .dyn_code_i(dyn_code_i),
		.param_wr_i(param_wr), .param_val_i(param_val),
		.param_ans_o(param_ans_o), .code_o(code_o),
		.periph_err_o(periph_err_o), .led_red_o(led_red_o),
		.led_green_o(led_green_o), .led_yellow_o(led_yellow_o));
	sspr_master_model master (.clk_i(clk_i), .poll_i(poll),
		.code_i(code_o), .param_wr_o(param_wr), .param_val_o(param_val),
		.release_o(rel));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w,
			input logic [31:0] d);
		int i;
		wb_adr_i <= a;
		wb_we_i  <= w;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
		end
		if (i == 20) begin
			bad_count++;
			report_and_stop();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic diag(input logic [3:0] exp);
		poll <= 1'b1;
		cyc(1);
		poll <= 1'b0;
		cyc(3);
		chk(param_ans_o, exp);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk(param_ans_o, 4'hf);
		chk(code_o, 4'h0);
		wb(8'h40, 1'b0, 32'h0);
		chk(rd, 32'h0);
		wb(8'h00, 1'b1, 32'h1);
		wb(8'h00, 1'b0, 32'h0);
		chk(rd, 32'h1);
	endtask
	task automatic t_teach();
		power_on_i <= 1'b1;
		cyc(10);
		act_present_i <= 1'b1;
		cyc(10);
		ones = 0;
		repeat (SEC) begin
			@(posedge clk_i);
			ones += int'(led_yellow_o === 1'b1);
		end
		chk(ones, SEC / 2);
		cyc(SEC + 100);
		wb(8'h04, 1'b0, 32'h0);
		chk(rd[2:0], 3'h3);
		power_on_i <= 1'b0;
		cyc(100);
		power_on_i <= 1'b1;
		cyc(100);
		wb(8'h04, 1'b0, 32'h0);
		chk(rd[2:0], 3'h6);
		chk({code_o, periph_err_o, led_yellow_o}, 6'h2);
		diag(4'h5);
	endtask
	task automatic t_inhibit_end();
		cyc(3 * SEC + 100);
		chk({code_o, periph_err_o, rel}, {dyn_code_i, 2'b01});
		hyst_i <= 1'b1;
		cyc(3);
		chk(periph_err_o, 1'b1);
		hyst_i <= 1'b0;
		cyc(3);
	endtask
	task automatic t_defect();
		defect_i <= 1'b1;
		cyc(3);
		chk({code_o, periph_err_o}, 5'h01);
		defect_i <= 1'b0;
		cyc(3);
		chk(code_o, 4'h0);
		act_present_i <= 1'b0;
		cyc(5);
		act_present_i <= 1'b1;
		cyc(5);
		chk(code_o, dyn_code_i);
	endtask
	task automatic t_bus_and_number();
		addr_zero_i <= 1'b1;
		cyc(3);
		chk({led_red_o, led_green_o, code_o}, 6'h20);
		addr_zero_i <= 1'b0;
		wb(8'h00, 1'b1, 32'h3);
		diag(act_num_i);
		act_present_i <= 1'b0;
		cyc(3);
		diag(4'h0);
	endtask
	task automatic t_abort();
		power_on_i <= 1'b0;
		cyc(5);
		power_on_i <= 1'b1;
		act_code_i <= 8'h33;
		cyc(5);
		act_present_i <= 1'b1;
		cyc(5 * SEC + 100);
		wb(8'h04, 1'b0, 32'h0);
		chk(rd[4:0], 5'h17);
		ones = 0;
		repeat (4 * SEC) begin
			@(posedge clk_i);
			ones += int'(led_yellow_o === 1'b1);
		end
		chk(ones, 5 * SEC / 4);
		chk({code_o, periph_err_o}, 5'h01);
	endtask
	initial begin
		cyc(5);
		rst_i <= 1'b0;
		cyc(2);
		t_reset();
		t_teach();
		t_inhibit_end();
		t_defect();
		t_bus_and_number();
		t_abort();
		report_and_stop();
	end
endmodule // tb_top
